/* File: nvm_ctl_pkg.sv */
// constants for the eeprom program and erase controller
package nvm_ctl_pkg;
    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_PROT  = 16'h1035;
    localparam logic [15:0] IDX_CTL   = 16'h103b;
    localparam logic [15:0] IDX_TEST  = 16'h103e;
    localparam logic [15:0] IDX_OPT   = 16'h103f;
    localparam logic [15:0] IDX_ARRAY = 16'h1200;
    // eeprom_program_control fields
    localparam int CTL_PUMP  = 0;
    localparam int CTL_LATCH = 1;
    localparam int CTL_ERASE = 2;
    localparam int CTL_ROW   = 3;
    localparam int CTL_BYTE  = 4;
    localparam int CTL_EVEN  = 6;
    localparam int CTL_ODD   = 7;
    localparam logic [7:0] CTL_WMASK = 8'hdf;
    localparam logic [7:0] CTL_RESET = 8'h00;
    // block_protect_register fields
    localparam int PROT_OPT = 4;
    localparam logic [7:0] PROT_MASK   = 8'h1f;
    localparam logic [7:0] PROT_RESET  = 8'h1f;
    localparam logic [6:0] PROT_WINDOW = 7'h40;
    // factory_test_register fields
    localparam int TEST_DISABLE_RESETS_TEST_BIT = 2;
    localparam logic [7:0] TEST_MASK  = 8'h04;
    localparam logic [7:0] TEST_RESET = 8'h00;
    // nonvolatile_system_options fields
    localparam int OPT_ARRAY_ENABLE_BIT  = 0;
    localparam int OPT_WATCHDOG_DISABLE_BIT = 2;
    localparam logic [7:0] OPT_UNIMP = 8'h0a;
    localparam logic [3:0] MAP_ALL1  = 4'hf;
    localparam logic [7:0] ERASED    = 8'hff;
    // array geometry and protect block bounds
    localparam int ARRAY_BYTES = 512;
    localparam logic [8:0] BLK1_LO = 9'h020;
    localparam logic [8:0] BLK2_LO = 9'h060;
    localparam logic [8:0] BLK3_LO = 9'h0e0;
    // operating mode pin codes and axi response codes
    localparam logic [1:0] MODE_BOOT   = 2'h0;
    localparam logic [1:0] MODE_TEST   = 2'h1;
    localparam logic [1:0] MODE_SINGLE = 2'h2;
    localparam logic [1:0] MODE_EXP    = 2'h3;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    function automatic logic [15:0] byte_addr(input logic [15:0] idx);
        return {idx[13:0], 2'h0};
    endfunction
endpackage

/* File: nv_cell_array.sv */
// eeprom cells: 512-byte array and the option byte
`timescale 1ns/1ps
module nv_cell_array (
    // clock
    input  wire logic       aclk,
    // operation strobe from the controller
    input  wire logic       op_go,
    input  wire logic [7:0] op_ctl,
    input  wire logic       op_option,
    input  wire logic [8:0] op_addr,
    input  wire logic [7:0] op_data,
    input  wire logic [4:0] protect,
    // read side
    input  wire logic [8:0] rd_addr,
    output logic      [7:0] rd_data,
    output logic      [7:0] opt_cell
);
    typedef struct packed {
        logic [nvm_ctl_pkg::ARRAY_BYTES-1:0][7:0] cells;
        logic [7:0]                                opt;
    } cell_state_t;

    // cells are nonvolatile: no reset, shipped erased
    cell_state_t q = '1;
    cell_state_t d;

    function automatic logic hit(input logic [8:0] a, input logic [8:0] t,
                                 input logic [7:0] c, input logic [3:0] bp);
        logic       in_scope;
        logic       par_ok;
        logic [1:0] blk;
        if (!c[nvm_ctl_pkg::CTL_ERASE] || c[nvm_ctl_pkg::CTL_BYTE]) begin
            in_scope = (a == t);
        end else if (c[nvm_ctl_pkg::CTL_ROW]) begin
            in_scope = (a[8:4] == t[8:4]);
        end else begin
            in_scope = 1'b1;
        end
        if (c[nvm_ctl_pkg::CTL_ODD] && !c[nvm_ctl_pkg::CTL_EVEN]) begin
            par_ok = a[4];
        end else if (c[nvm_ctl_pkg::CTL_EVEN] && !c[nvm_ctl_pkg::CTL_ODD]) begin
            par_ok = !a[4];
        end else begin
            par_ok = 1'b1;
        end
        if (a < nvm_ctl_pkg::BLK1_LO) begin
            blk = 2'h0;
        end else if (a < nvm_ctl_pkg::BLK2_LO) begin
            blk = 2'h1;
        end else if (a < nvm_ctl_pkg::BLK3_LO) begin
            blk = 2'h2;
        end else begin
            blk = 2'h3;
        end
        return in_scope && par_ok && !bp[blk];
    endfunction

    always_comb begin
        d = q;
        if (op_go && op_option) begin
            if (!protect[nvm_ctl_pkg::PROT_OPT]) begin
                d.opt = op_ctl[nvm_ctl_pkg::CTL_ERASE] ? nvm_ctl_pkg::ERASED
                                                       : q.opt & op_data;
            end
        end else if (op_go) begin
            for (int i = 0; i < nvm_ctl_pkg::ARRAY_BYTES; i++) begin
                if (hit(9'(i), op_addr, op_ctl, protect[3:0])) begin
                    // program only pulls ones to zero
                    d.cells[i] = op_ctl[nvm_ctl_pkg::CTL_ERASE]
                               ? nvm_ctl_pkg::ERASED
                               : q.cells[i] & op_data;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        q <= d;
    end

    assign rd_data  = q.cells[rd_addr];
    assign opt_cell = q.opt;
endmodule

/* File: nvm_ctl.sv */
// eeprom program and erase controller with axi4-lite registers
`timescale 1ns/1ps
module nvm_ctl (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write
    input  wire logic [15:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // axi4-lite read
    input  wire logic [15:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // mode pins
    input  wire logic [1:0]  mode_pins,
    // effective options and pump status
    output logic [3:0]       array_map_select,
    output logic             array_enable_bit,
    output logic             watchdog_enable,
    output logic             pump_voltage_on,
    output logic             erase_voltage_on
);
    typedef struct packed {
        logic [1:0]  m1;
        logic [1:0]  m2;
        logic [7:0]  ctl;
        logic [7:0]  prot;
        logic [7:0]  test;
        logic [7:0]  opt_ld;
        logic [6:0]  cnt;
        logic        capt;
        logic        cap_opt;
        logic [8:0]  cap_addr;
        logic [7:0]  cap_data;
        logic        go;
        logic [7:0]  op_ctl;
        logic        aw_have;
        logic [15:0] aw_addr;
        logic        w_have;
        logic [7:0]  w_data;
        logic        w_en;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        pump_out;
        logic        erase_out;
        logic        wdog;
    } state_t;

    state_t     q;
    state_t     d;
    state_t     r;
    logic [7:0] rd_data;
    logic [7:0] opt_cell;
    logic       wr_go;
    logic       wr_ctl;
    logic       wr_arr;
    logic [7:0] wd;

    function automatic logic in_array(input logic [15:0] a);
        logic [15:0] b;
        b = nvm_ctl_pkg::byte_addr(nvm_ctl_pkg::IDX_ARRAY);
        return a[15:11] == b[15:11];
    endfunction

    function automatic logic [7:0] load_opt(input logic [7:0] c,
                                            input logic [1:0] m);
        logic [7:0] v;
        v = c | nvm_ctl_pkg::OPT_UNIMP;
        if (m == nvm_ctl_pkg::MODE_SINGLE || m == nvm_ctl_pkg::MODE_BOOT) begin
            v[7:4] = nvm_ctl_pkg::MAP_ALL1;
            v[nvm_ctl_pkg::OPT_ARRAY_ENABLE_BIT] = 1'b1;
        end else if (m == nvm_ctl_pkg::MODE_TEST) begin
            v[nvm_ctl_pkg::OPT_ARRAY_ENABLE_BIT] = 1'b0;
        end
        return v;
    endfunction

    function automatic logic wdog_en(input logic [7:0] o, input logic [7:0] t,
                                     input logic [1:0] m);
        if (m == nvm_ctl_pkg::MODE_BOOT || m == nvm_ctl_pkg::MODE_TEST) begin
            return !t[nvm_ctl_pkg::TEST_DISABLE_RESETS_TEST_BIT];
        end
        return !o[nvm_ctl_pkg::OPT_WATCHDOG_DISABLE_BIT];
    endfunction

    assign wr_go  = q.aw_have & q.w_have & ~q.bvalid;
    assign wr_ctl = wr_go & q.w_en
                  & (q.aw_addr == nvm_ctl_pkg::byte_addr(nvm_ctl_pkg::IDX_CTL));
    assign wr_arr = wr_go & q.w_en & in_array(q.aw_addr);
    assign wd     = q.w_data & nvm_ctl_pkg::CTL_WMASK;

    always_comb begin
        // reset image: option byte is loaded only here
        r          = '0;
        r.m1       = mode_pins;
        r.m2       = q.m1;
        r.ctl      = nvm_ctl_pkg::CTL_RESET;
        r.prot     = nvm_ctl_pkg::PROT_RESET;
        r.test     = nvm_ctl_pkg::TEST_RESET;
        r.opt_ld   = load_opt(opt_cell, q.m2);
        r.wdog     = wdog_en(r.opt_ld, nvm_ctl_pkg::TEST_RESET, q.m2);
        r.awready  = 1'b1;
        r.wready   = 1'b1;
        r.arready  = 1'b1;

        d      = q;
        d.m1   = mode_pins;
        d.m2   = q.m1;
        d.go   = 1'b0;
        if (q.cnt != nvm_ctl_pkg::PROT_WINDOW) begin
            d.cnt = q.cnt + 7'h1;
        end
        if (awvalid && q.awready) begin
            d.aw_have = 1'b1;
            d.aw_addr = awaddr;
        end
        if (wvalid && q.wready) begin
            d.w_have = 1'b1;
            d.w_data = wdata[7:0];
            d.w_en   = wstrb[0];
        end
        if (bready && q.bvalid) begin
            d.bvalid = 1'b0;
        end
        if (wr_go) begin
            d.aw_have = 1'b0;
            d.w_have  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = nvm_ctl_pkg::RESP_OKAY;
            if (!q.w_en) begin
                // lane 0 not strobed: nothing stored
            end else if (wr_ctl) begin
                d.ctl = wd;
                // pump needs an earlier latch-only write
                d.ctl[nvm_ctl_pkg::CTL_LATCH] = wd[nvm_ctl_pkg::CTL_LATCH]
                    & ~(wd[nvm_ctl_pkg::CTL_PUMP]
                        & ~q.ctl[nvm_ctl_pkg::CTL_LATCH]);
                d.ctl[nvm_ctl_pkg::CTL_PUMP] = q.ctl[nvm_ctl_pkg::CTL_LATCH]
                    ? wd[nvm_ctl_pkg::CTL_PUMP]
                    : q.ctl[nvm_ctl_pkg::CTL_PUMP];
            end else if (q.aw_addr ==
                         nvm_ctl_pkg::byte_addr(nvm_ctl_pkg::IDX_PROT)) begin
                if (q.cnt != nvm_ctl_pkg::PROT_WINDOW) begin
                    d.prot = q.w_data & nvm_ctl_pkg::PROT_MASK;
                end else begin
                    d.prot = q.prot | (q.w_data & nvm_ctl_pkg::PROT_MASK);
                end
            end else if (q.aw_addr ==
                         nvm_ctl_pkg::byte_addr(nvm_ctl_pkg::IDX_TEST)) begin
                d.test = q.w_data & nvm_ctl_pkg::TEST_MASK;
            end else if (q.aw_addr ==
                         nvm_ctl_pkg::byte_addr(nvm_ctl_pkg::IDX_OPT)
                         || wr_arr) begin
                // latch clear: read-only; pump set: leave operation alone
                if (q.ctl[nvm_ctl_pkg::CTL_LATCH]
                    && !q.ctl[nvm_ctl_pkg::CTL_PUMP]) begin
                    d.capt     = 1'b1;
                    d.cap_opt  = !wr_arr;
                    d.cap_addr = q.aw_addr[10:2];
                    d.cap_data = q.w_data;
                end
            end else begin
                d.bresp = nvm_ctl_pkg::RESP_DECERR;
            end
        end
        // operation lands when the voltage is switched off
        if (q.ctl[nvm_ctl_pkg::CTL_PUMP] && !d.ctl[nvm_ctl_pkg::CTL_PUMP]
            && q.capt) begin
            d.go     = 1'b1;
            d.op_ctl = q.ctl;
            d.capt   = 1'b0;
        end
        if (!d.ctl[nvm_ctl_pkg::CTL_LATCH]) begin
            d.capt = 1'b0;
        end
        d.pump_out  = d.ctl[nvm_ctl_pkg::CTL_PUMP] & d.capt;
        d.erase_out = d.pump_out & d.ctl[nvm_ctl_pkg::CTL_ERASE];
        d.wdog      = wdog_en(q.opt_ld, d.test, q.m2);

        if (rready && q.rvalid) begin
            d.rvalid = 1'b0;
        end
        if (arvalid && q.arready) begin
            d.rvalid = 1'b1;
            d.rresp  = nvm_ctl_pkg::RESP_OKAY;
            d.rdata  = '0;
            if (araddr == nvm_ctl_pkg::byte_addr(nvm_ctl_pkg::IDX_CTL)) begin
                d.rdata[7:0] = q.ctl;
            end else if (araddr ==
                         nvm_ctl_pkg::byte_addr(nvm_ctl_pkg::IDX_PROT)) begin
                d.rdata[7:0] = q.prot;
            end else if (araddr ==
                         nvm_ctl_pkg::byte_addr(nvm_ctl_pkg::IDX_TEST)) begin
                d.rdata[7:0] = q.test;
            end else if (araddr ==
                         nvm_ctl_pkg::byte_addr(nvm_ctl_pkg::IDX_OPT)) begin
                d.rdata[7:0] = q.opt_ld;
            end else if (in_array(araddr)) begin
                if (!q.ctl[nvm_ctl_pkg::CTL_LATCH]) begin
                    d.rdata[7:0] = rd_data;
                end
            end else begin
                d.rresp = nvm_ctl_pkg::RESP_DECERR;
            end
        end
        d.awready = ~d.aw_have;
        d.wready  = ~d.w_have;
        d.arready = ~d.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= r;
        end else begin
            q <= d;
        end
    end

    nv_cell_array cells (
        .aclk      (aclk),
        .op_go     (q.go),
        .op_ctl    (q.op_ctl),
        .op_option (q.cap_opt),
        .op_addr   (q.cap_addr),
        .op_data   (q.cap_data),
        .protect   (q.prot[4:0]),
        .rd_addr   (araddr[10:2]),
        .rd_data   (rd_data),
        .opt_cell  (opt_cell)
    );

    assign awready          = q.awready;
    assign wready           = q.wready;
    assign bvalid           = q.bvalid;
    assign bresp            = q.bresp;
    assign arready          = q.arready;
    assign rvalid           = q.rvalid;
    assign rresp            = q.rresp;
    assign rdata            = q.rdata;
    assign array_map_select = q.opt_ld[7:4];
    assign array_enable_bit = q.opt_ld[nvm_ctl_pkg::OPT_ARRAY_ENABLE_BIT];
    assign watchdog_enable  = q.wdog;
    assign pump_voltage_on  = q.pump_out;
    assign erase_voltage_on = q.erase_out;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    bit5_zero_a:
        assert property (rvalid && !$past(rvalid) && $past(araddr) ==
            nvm_ctl_pkg::byte_addr(nvm_ctl_pkg::IDX_CTL) |-> !rdata[5])
        else $error("control bit 5 read as one");
    pump_gate_a:
        assert property ($rose(q.ctl[nvm_ctl_pkg::CTL_PUMP])
                         |-> $past(q.ctl[nvm_ctl_pkg::CTL_LATCH]))
        else $error("pump set without prior latch");
    double_set_a:
        assert property (wr_ctl && wd[1:0] == 2'h3
                         && !q.ctl[nvm_ctl_pkg::CTL_LATCH]
                         |=> q.ctl[1:0] == 2'h0)
        else $error("latch and pump set in one write");
    pump_ignore_a:
        assert property (wr_arr && q.ctl[nvm_ctl_pkg::CTL_PUMP]
                         |=> $stable(q.cap_addr) && $stable(q.cap_data))
        else $error("array write disturbed running operation");
    go_capture_a:
        assert property (q.go |-> $past(q.capt)
                         && !q.ctl[nvm_ctl_pkg::CTL_PUMP])
        else $error("operation without captured write");
    rom_mode_a:
        assert property (!q.ctl[nvm_ctl_pkg::CTL_LATCH] |-> !q.capt)
        else $error("capture held while latch clear");
    prot_sticky_a:
        assert property (q.cnt == nvm_ctl_pkg::PROT_WINDOW ##1 1'b1
                         |-> (q.prot & $past(q.prot)) == $past(q.prot))
        else $error("protect bit cleared after window");
    opt_hold_a:
        assert property ($past(aresetn) |-> $stable(q.opt_ld))
        else $error("option value changed outside reset");
    pump_out_a:
        assert property (pump_voltage_on |-> q.capt
                         && q.ctl[nvm_ctl_pkg::CTL_PUMP])
        else $error("voltage on without latched operation");
    wr_resp_a:
        assert property (wr_go |=> bvalid && awready)
        else $error("write not answered next cycle");

    erase_op_c: cover property (q.go && q.op_ctl[nvm_ctl_pkg::CTL_ERASE]);
    prog_op_c:  cover property (q.go && !q.op_ctl[nvm_ctl_pkg::CTL_ERASE]);
    opt_op_c:   cover property (q.go && q.cap_opt);
    prot_clr_c: cover property ($fell(q.prot[0]));
endmodule

/* File: nvm_ctl_tb_top.sv */
// self-checking bench for the eeprom program and erase controller
`timescale 1ns/1ps
module nvm_ctl_tb_top;
    localparam logic [15:0] A_CTL  = nvm_ctl_pkg::IDX_CTL << 2;
    localparam logic [15:0] A_PROT = nvm_ctl_pkg::IDX_PROT << 2;
    localparam logic [15:0] A_TEST = nvm_ctl_pkg::IDX_TEST << 2;
    localparam logic [15:0] A_OPT  = nvm_ctl_pkg::IDX_OPT << 2;
    localparam logic [15:0] A_ARR  = nvm_ctl_pkg::IDX_ARRAY << 2;
    logic        aclk;
    logic        aresetn;
    logic [15:0] awaddr;
    logic        awvalid;
    logic        awready;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready;
    logic [15:0] araddr;
    logic        arvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready;
    logic [1:0]  mode_pins;
    logic [3:0]  array_map_select;
    logic        array_enable_bit;
    logic        watchdog_enable;
    logic        pump_voltage_on;
    logic        erase_voltage_on;
    int          n_errors = 0;
    int          check_count = 0;
    int          cycles = 0;

    nvm_ctl DUT (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .mode_pins(mode_pins), .array_map_select(array_map_select),
        .array_enable_bit(array_enable_bit),
        .watchdog_enable(watchdog_enable),
        .pump_voltage_on(pump_voltage_on),
        .erase_voltage_on(erase_voltage_on)
    );

    initial begin
        aclk = 1'h0;
        forever #12.5 aclk = ~aclk;
    end

    // hang guard: whole run needs a few hundred cycles
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            $display("[FAIL] cycles expected below %0d seen %0d", 20000,
                     cycles);
            n_errors++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask

    function automatic logic [15:0] arr(input int i);
        return A_ARR + 16'(i * 4);
    endfunction

    // mode decides which stored option bits survive the load
    function automatic logic [7:0] opt_exp(input logic [7:0] s,
                                           input logic [1:0] m);
        logic sc;
        sc = (m == nvm_ctl_pkg::MODE_SINGLE) || (m == nvm_ctl_pkg::MODE_BOOT);
        return {sc ? 4'hf : s[7:4], 1'h1, s[2], 1'h1,
                sc | ((m == nvm_ctl_pkg::MODE_EXP) & s[0])};
    endfunction

    task automatic rst(input logic [1:0] m);
        @(posedge aclk);
        mode_pins <= m;
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
    endtask

    task automatic wr_raw(input logic [15:0] a, input logic [7:0] d,
                          output logic [1:0] r);
        int n;
        bit done;
        n = 0;
        done = 0;
        r = 2'h2;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= {24'h00_0000, d};
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        while (!done && n < 50) begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid && bready) begin
                r = bresp;
                done = 1;
            end
        end
        bready <= 1'h0;
        if (!done) begin
            $display("[FAIL] bvalid expected 1 seen 0");
            n_errors++;
        end
    endtask

    task automatic rd_raw(input logic [15:0] a, output logic [7:0] d,
                          output logic [1:0] r);
        int n;
        bit done;
        n = 0;
        done = 0;
        r = 2'h2;
        d = 8'h00;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        while (!done && n < 50) begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid && rready) begin
                d = rdata[7:0];
                r = rresp;
                done = 1;
            end
        end
        rready <= 1'h0;
        if (!done) begin
            $display("[FAIL] rvalid expected 1 seen 0");
            n_errors++;
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [1:0] r;
        wr_raw(a, d, r);
        chk("bresp", {6'h00, nvm_ctl_pkg::RESP_OKAY}, {6'h00, r});
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e,
                      input string nm);
        logic [7:0] d;
        logic [1:0] r;
        rd_raw(a, d, r);
        chk(nm, e, d);
        chk("rresp", {6'h00, nvm_ctl_pkg::RESP_OKAY}, {6'h00, r});
    endtask

    // latch, capture, pump, stray write, clear
    task automatic op(input logic [7:0] c, input logic [15:0] a,
                      input logic [7:0] d, input bit tgt, input bit ep);
        wr(A_CTL, c);
        if (tgt) wr(a, d);
        wr(A_CTL, c | 8'h01);
        repeat (2) @(posedge aclk);
        chk("pump_on", {7'h00, ep}, {7'h00, pump_voltage_on});
        chk("erase_on", {7'h00, ep & c[2]},
            {7'h00, erase_voltage_on});
        wr(a, ~d);
        wr(A_CTL, 8'h00);
    endtask

    task automatic t_first();
        logic [7:0] d;
        logic [1:0] r;
        wr(A_PROT, 8'h10);
        rd(A_PROT, 8'h10, "prot");
        rd(A_CTL, 8'h00, "ctl_reset");
        rd(A_OPT, 8'hff, "opt_reset");
        chk("map", 8'h0f, {4'h0, array_map_select});
        chk("wdog", 8'h00, {7'h00, watchdog_enable});
        wr_raw(16'h4000, 8'h12, r);
        chk("bresp_unmapped", {6'h00, nvm_ctl_pkg::RESP_DECERR}, {6'h00, r});
        rd_raw(16'h4000, d, r);
        chk("rresp_unmapped", {6'h00, nvm_ctl_pkg::RESP_DECERR}, {6'h00, r});
        chk("rdata_unmapped", 8'h00, d);
    endtask

    task automatic t_ctl();
        wr(A_CTL, 8'hff);
        rd(A_CTL, 8'hdc, "ctl_both");
        wr(A_CTL, 8'h01);
        rd(A_CTL, 8'h00, "pump_no_latch");
        // lane 0 not strobed: control must not move
        wstrb <= 4'he;
        wr(A_CTL, 8'h02);
        wstrb <= 4'hf;
        rd(A_CTL, 8'h00, "ctl_no_strobe");
        wr(A_ARR, 8'h00);
        rd(A_ARR, 8'hff, "rom_write");
        op(8'h02, arr(0), 8'h00, 1'h0, 1'h0);
        rd(A_ARR, 8'hff, "no_capture");
    endtask

    task automatic t_program();
        op(8'h02, arr(5), 8'ha5, 1'h1, 1'h1);
        rd(arr(5), 8'ha5, "prog1");
        op(8'h02, arr(5), 8'h5a, 1'h1, 1'h1);
        rd(arr(5), 8'h00, "prog_and");
        op(8'h82, arr(0), 8'h00, 1'h1, 1'h1);
        rd(arr(0), 8'hff, "odd_only");
        op(8'h42, arr(0), 8'h00, 1'h1, 1'h1);
        rd(arr(0), 8'h00, "even_only");
        op(8'h02, A_OPT, 8'h0f, 1'h1, 1'h1);
    endtask

    task automatic t_erase();
        op(8'h02, arr('h10), 8'h00, 1'h1, 1'h1);
        op(8'h02, arr('h11), 8'h00, 1'h1, 1'h1);
        op(8'h02, arr('h20), 8'h00, 1'h1, 1'h1);
        op(8'h1e, arr('h10), 8'h00, 1'h1, 1'h1);
        rd(arr('h10), 8'hff, "byte_erase");
        rd(arr('h11), 8'h00, "byte_only");
        op(8'h0e, arr('h1f), 8'h00, 1'h1, 1'h1);
        rd(arr('h11), 8'hff, "row_erase");
        rd(arr('h20), 8'h00, "next_row");
        op(8'h06, arr('h1ff), 8'h00, 1'h1, 1'h1);
        rd(arr('h20), 8'hff, "bulk_mid");
        rd(arr(5), 8'hff, "bulk_low");
    endtask

    task automatic t_option();
        logic [1:0] m;
        logic [7:0] e;
        bit tm;
        rst(nvm_ctl_pkg::MODE_EXP);
        wr(A_PROT, 8'h00);
        rd(A_OPT, 8'hff, "opt_locked");
        op(8'h02, A_OPT, 8'h50, 1'h1, 1'h1);
        rd(A_OPT, 8'hff, "opt_pending");
        for (int k = 0; k < 4; k++) begin
            m = 2'(3 - k);
            rst(m);
            wr(A_PROT, 8'h00);
            e = opt_exp(8'h50, m);
            tm = (m == nvm_ctl_pkg::MODE_BOOT) || (m == nvm_ctl_pkg::MODE_TEST);
            rd(A_OPT, e, "opt_load");
            chk("map", {4'h0, e[7:4]}, {4'h0, array_map_select});
            chk("ee_on", {7'h00, e[0]}, {7'h00, array_enable_bit});
            wr(A_TEST, 8'h04);
            repeat (2) @(posedge aclk);
            chk("wdog", {7'h00, !tm}, {7'h00, watchdog_enable});
        end
        op(8'h16, A_OPT, 8'h00, 1'h1, 1'h1);
        rst(nvm_ctl_pkg::MODE_EXP);
        wr(A_PROT, 8'h00);
        rd(A_OPT, 8'hff, "opt_erased");
    endtask

    // protect may only be raised once the early window has closed
    task automatic t_late();
        repeat (70) @(posedge aclk);
        wr(A_PROT, 8'h01);
        wr(A_PROT, 8'h00);
        rd(A_PROT, 8'h01, "prot_late");
        op(8'h02, arr(3), 8'h00, 1'h1, 1'h1);
        rd(arr(3), 8'hff, "prot_block");
    endtask

    initial begin
        aresetn   = 1'h0;
        mode_pins = nvm_ctl_pkg::MODE_SINGLE;
        awaddr    = 16'h0000;
        awvalid   = 1'h0;
        wdata     = 32'h0000_0000;
        wstrb     = 4'hf;
        wvalid    = 1'h0;
        bready    = 1'h0;
        araddr    = 16'h0000;
        arvalid   = 1'h0;
        rready    = 1'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_first();
        t_ctl();
        t_program();
        t_erase();
        t_option();
        t_late();
        results();
    end
endmodule
